// ===== common/cpdma_map.svh
`ifndef CPDMA_MAP_SVH
`define CPDMA_MAP_SVH

// Byte addresses of the registers
`define CPDMA_ADR_CODEC_STATUS 32'h4f00_0064
`define CPDMA_ADR_FRAME1_BASE 32'h4f00_006c
`define CPDMA_ADR_FRAME2_BASE 32'h4f00_0070
`define CPDMA_ADR_FRAME3_BASE 32'h4f00_0074
`define CPDMA_ADR_FRAME4_BASE 32'h4f00_0078
`define CPDMA_ADR_TARGET_FMT 32'h4f00_007c
`define CPDMA_ADR_DMA_CTRL 32'h4f00_0080
`define CPDMA_ADR_PRE_RATIO 32'h4f00_0084
`define CPDMA_ADR_PRE_DEST 32'h4f00_0088
`define CPDMA_ADR_IRQ_STATUS 32'h4f00_00b0
`define CPDMA_ADR_IRQ_MASK 32'h4f00_00b4

// Field positions
`define CPDMA_ST_LUMA 31
`define CPDMA_ST_BLUE 30
`define CPDMA_ST_RED 29
`define CPDMA_ST_VSYNC 28
`define CPDMA_ST_FCNT_HI 27
`define CPDMA_ST_FCNT_LO 26
`define CPDMA_ST_WOFS 25
`define CPDMA_ST_FLIP_HI 24
`define CPDMA_ST_FLIP_LO 23
`define CPDMA_ST_CAP_IF 22
`define CPDMA_ST_CAP_CO 21
`define CPDMA_TF_W_HI 28
`define CPDMA_TF_W_LO 16
`define CPDMA_TF_FLIP_HI 15
`define CPDMA_TF_FLIP_LO 14
`define CPDMA_TF_H_HI 12
`define CPDMA_TF_H_LO 0
`define CPDMA_CT_MAIN_HI 23
`define CPDMA_CT_MAIN_LO 19
`define CPDMA_CT_TAIL_HI 18
`define CPDMA_CT_TAIL_LO 14
`define CPDMA_CT_ARM 2
`define CPDMA_PR_SH_HI 31
`define CPDMA_PR_SH_LO 28
`define CPDMA_PR_H_HI 22
`define CPDMA_PR_H_LO 16
`define CPDMA_PR_V_HI 6
`define CPDMA_PR_V_LO 0
`define CPDMA_PD_W_HI 27
`define CPDMA_PD_W_LO 16
`define CPDMA_PD_H_HI 11
`define CPDMA_PD_H_LO 0
`define CPDMA_IRQ_FRAME 0
`define CPDMA_IRQ_LAST 1

// Reset values
`define CPDMA_RST_WORD 32'h0000_0000
`define CPDMA_RST_IRQ 2'h0

`endif

// ===== common/cpdma_pkg.sv
package cpdma_pkg;

   typedef struct packed {
      logic luma_ovf;
      logic blue_ovf;
      logic red_ovf;
      logic vsync;
      logic [1:0] next_frame;
      logic win_ofs;
      logic [1:0] orient;
      logic if_cap;
      logic codec_cap;
   } cpdma_codec_s;

   typedef struct packed {
      logic [3:0] shift;
      logic [6:0] h_ratio;
      logic [6:0] v_ratio;
      logic [11:0] out_width;
      logic [11:0] out_height;
   } cpdma_scale_s;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } cpdma_state_e;

endpackage

// ===== core/cpdma_top.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`include "cpdma_map.svh"

// Summary of operation
// - Status top three bits show codec luma, blue and red FIFO overflow.
// - Status bit 28 mirrors camera vertical sync, also in embedded-sync mode.
// - Status holds two-bit codec frame counter giving the next frame index.
// - Status bit shows whether the window offset function is enabled.
// - Status two-bit field shows codec flip mode in effect.
// - Status shows capture-enable of whole interface and of codec path.
// - Four 32-bit preview frame start addresses, cleared at reset.
// - Preview output height comes from bits 12:0 of target format.
// - Orientation 00 normal, 01 Y mirror, 10 X mirror, 11 rotate 180.
// - Main and tail burst lengths come from two 5-bit control fields.
// - Armed bit raises interrupt at frame end, then clears itself.
// - Pre-scaler shift, horizontal and vertical ratio taken from ratio register.
// - Pre-scaler output width and height from two 12-bit fields.
module cpdma_top
   import cpdma_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire cpdma_codec_s i_codec,
   input wire logic i_preview_capture_en,
   input wire logic i_frame_start,
   input wire logic i_pix_valid,
   input wire logic [31:0] i_pix_data,
   output logic o_pix_ready,
   output logic o_mem_valid,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_data,
   output logic o_mem_first,
   output logic [4:0] o_mem_blen,
   input wire logic i_mem_ready,
   output logic [1:0] o_frame_index,
   output logic o_busy,
   output cpdma_scale_s o_scale,
   output logic o_irq
);

   logic [31:0] frame_base [0:3];
   logic [12:0] preview_out_width;
   logic [1:0] preview_orientation;
   logic [12:0] preview_out_height;
   logic [4:0] preview_main_burst_len;
   logic [4:0] preview_tail_burst_len;
   logic preview_final_frame_irq_arm;
   logic [31:0] codec_path_status;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [1:0] next_irq_status;

   cpdma_state_e state;
   logic [12:0] pos_x;
   logic [12:0] pos_y;
   logic [4:0] burst_left;
   logic last_pending;

   logic bus_hit;
   logic bus_wr;
   logic [31:0] rd_word;
   logic take_pix;
   logic beat_done;
   logic frame_end;
   logic start_ok;
   logic line_last;
   logic [12:0] words_left;
   logic [4:0] pick_len;
   logic [12:0] addr_x;
   logic [12:0] addr_y;
   logic [25:0] lin_idx;
   logic [31:0] pix_addr;
   logic wr_ctrl;

   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   assign bus_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign bus_wr = bus_hit & i_wb_we;
   assign wr_ctrl = bus_wr && (i_wb_adr == `CPDMA_ADR_DMA_CTRL);

   // Current register images
   logic [31:0] fmt_word;
   logic [31:0] ctrl_word;
   logic [31:0] ratio_word;
   logic [31:0] dest_word;

   always_comb begin
      fmt_word = `CPDMA_RST_WORD;
      fmt_word[`CPDMA_TF_W_HI:`CPDMA_TF_W_LO] = preview_out_width;
      fmt_word[`CPDMA_TF_FLIP_HI:`CPDMA_TF_FLIP_LO] = preview_orientation;
      fmt_word[`CPDMA_TF_H_HI:`CPDMA_TF_H_LO] = preview_out_height;
      ctrl_word = `CPDMA_RST_WORD;
      ctrl_word[`CPDMA_CT_MAIN_HI:`CPDMA_CT_MAIN_LO] = preview_main_burst_len;
      ctrl_word[`CPDMA_CT_TAIL_HI:`CPDMA_CT_TAIL_LO] = preview_tail_burst_len;
      ctrl_word[`CPDMA_CT_ARM] = preview_final_frame_irq_arm;
      ratio_word = `CPDMA_RST_WORD;
      ratio_word[`CPDMA_PR_SH_HI:`CPDMA_PR_SH_LO] = o_scale.shift;
      ratio_word[`CPDMA_PR_H_HI:`CPDMA_PR_H_LO] = o_scale.h_ratio;
      ratio_word[`CPDMA_PR_V_HI:`CPDMA_PR_V_LO] = o_scale.v_ratio;
      dest_word = `CPDMA_RST_WORD;
      dest_word[`CPDMA_PD_W_HI:`CPDMA_PD_W_LO] = o_scale.out_width;
      dest_word[`CPDMA_PD_H_HI:`CPDMA_PD_H_LO] = o_scale.out_height;
   end

   always_comb begin
      unique case (i_wb_adr)
         `CPDMA_ADR_CODEC_STATUS: rd_word = codec_path_status;
         `CPDMA_ADR_FRAME1_BASE: rd_word = frame_base[0];
         `CPDMA_ADR_FRAME2_BASE: rd_word = frame_base[1];
         `CPDMA_ADR_FRAME3_BASE: rd_word = frame_base[2];
         `CPDMA_ADR_FRAME4_BASE: rd_word = frame_base[3];
         `CPDMA_ADR_TARGET_FMT: rd_word = fmt_word;
         `CPDMA_ADR_DMA_CTRL: rd_word = ctrl_word;
         `CPDMA_ADR_PRE_RATIO: rd_word = ratio_word;
         `CPDMA_ADR_PRE_DEST: rd_word = dest_word;
         `CPDMA_ADR_IRQ_STATUS: rd_word = {30'h0000_0000, irq_status};
         `CPDMA_ADR_IRQ_MASK: rd_word = {30'h0000_0000, irq_mask};
         default: rd_word = `CPDMA_RST_WORD;
      endcase
   end

   // Bus answer: one wait state, unmapped addresses read zero
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= `CPDMA_RST_WORD;
      end else begin
         o_wb_ack <= bus_hit;
         o_wb_dat <= (bus_hit && !i_wb_we) ? rd_word : `CPDMA_RST_WORD;
      end
   end

   // Codec status is sampled from live state; bus writes never reach it
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         codec_path_status <= `CPDMA_RST_WORD;
      end else begin
         codec_path_status <= `CPDMA_RST_WORD;
         codec_path_status[`CPDMA_ST_LUMA] <= i_codec.luma_ovf;
         codec_path_status[`CPDMA_ST_BLUE] <= i_codec.blue_ovf;
         codec_path_status[`CPDMA_ST_RED] <= i_codec.red_ovf;
         codec_path_status[`CPDMA_ST_VSYNC] <= i_codec.vsync;
         codec_path_status[`CPDMA_ST_FCNT_HI:`CPDMA_ST_FCNT_LO] <=
            i_codec.next_frame;
         codec_path_status[`CPDMA_ST_WOFS] <= i_codec.win_ofs;
         codec_path_status[`CPDMA_ST_FLIP_HI:`CPDMA_ST_FLIP_LO] <=
            i_codec.orient;
         codec_path_status[`CPDMA_ST_CAP_IF] <= i_codec.if_cap;
         codec_path_status[`CPDMA_ST_CAP_CO] <= i_codec.codec_cap;
      end
   end

   // Frame start addresses
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         for (int i = 0; i < 4; i++) begin
            frame_base[i] <= `CPDMA_RST_WORD;
         end
      end else if (bus_wr) begin
         unique case (i_wb_adr)
            `CPDMA_ADR_FRAME1_BASE: frame_base[0] <= merge(frame_base[0], i_wb_dat, i_wb_sel);
            `CPDMA_ADR_FRAME2_BASE: frame_base[1] <= merge(frame_base[1], i_wb_dat, i_wb_sel);
            `CPDMA_ADR_FRAME3_BASE: frame_base[2] <= merge(frame_base[2], i_wb_dat, i_wb_sel);
            `CPDMA_ADR_FRAME4_BASE: frame_base[3] <= merge(frame_base[3], i_wb_dat, i_wb_sel);
            default: begin
            end
         endcase
      end
   end

   // Target format and pre-scaler settings
   logic [31:0] fmt_new;
   logic [31:0] ratio_new;
   logic [31:0] dest_new;
   logic [31:0] ctrl_new;
   assign fmt_new = merge(fmt_word, i_wb_dat, i_wb_sel);
   assign ratio_new = merge(ratio_word, i_wb_dat, i_wb_sel);
   assign dest_new = merge(dest_word, i_wb_dat, i_wb_sel);
   assign ctrl_new = merge(ctrl_word, i_wb_dat, i_wb_sel);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         preview_out_width <= 13'h0000;
         preview_orientation <= 2'h0;
         preview_out_height <= 13'h0000;
      end else if (bus_wr && (i_wb_adr == `CPDMA_ADR_TARGET_FMT)) begin
         preview_out_width <= fmt_new[`CPDMA_TF_W_HI:`CPDMA_TF_W_LO];
         preview_orientation <= fmt_new[`CPDMA_TF_FLIP_HI:`CPDMA_TF_FLIP_LO];
         preview_out_height <= fmt_new[`CPDMA_TF_H_HI:`CPDMA_TF_H_LO];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_scale <= '0;
      end else begin
         if (bus_wr && (i_wb_adr == `CPDMA_ADR_PRE_RATIO)) begin
            o_scale.shift <= ratio_new[`CPDMA_PR_SH_HI:`CPDMA_PR_SH_LO];
            o_scale.h_ratio <= ratio_new[`CPDMA_PR_H_HI:`CPDMA_PR_H_LO];
            o_scale.v_ratio <= ratio_new[`CPDMA_PR_V_HI:`CPDMA_PR_V_LO];
         end
         if (bus_wr && (i_wb_adr == `CPDMA_ADR_PRE_DEST)) begin
            o_scale.out_width <= dest_new[`CPDMA_PD_W_HI:`CPDMA_PD_W_LO];
            o_scale.out_height <= dest_new[`CPDMA_PD_H_HI:`CPDMA_PD_H_LO];
         end
      end
   end

   // DMA control; a bus write in the frame-end cycle overrides the self clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         preview_main_burst_len <= 5'h00;
         preview_tail_burst_len <= 5'h00;
         preview_final_frame_irq_arm <= 1'b0;
      end else if (wr_ctrl) begin
         preview_main_burst_len <= ctrl_new[`CPDMA_CT_MAIN_HI:`CPDMA_CT_MAIN_LO];
         preview_tail_burst_len <= ctrl_new[`CPDMA_CT_TAIL_HI:`CPDMA_CT_TAIL_LO];
         preview_final_frame_irq_arm <= ctrl_new[`CPDMA_CT_ARM];
      end else if (frame_end) begin
         preview_final_frame_irq_arm <= 1'b0;
      end
   end

   // Interrupt status: set wins over a write-one clear
   always_comb begin
      next_irq_status = irq_status;
      if (bus_wr && (i_wb_adr == `CPDMA_ADR_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~i_wb_dat[1:0];
      end
      if (frame_end) begin
         next_irq_status[`CPDMA_IRQ_FRAME] = 1'b1;
         if (preview_final_frame_irq_arm) begin
            next_irq_status[`CPDMA_IRQ_LAST] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         irq_status <= `CPDMA_RST_IRQ;
         irq_mask <= `CPDMA_RST_IRQ;
         o_irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (bus_wr && (i_wb_adr == `CPDMA_ADR_IRQ_MASK) && i_wb_sel[0]) begin
            irq_mask <= i_wb_dat[1:0];
         end
         o_irq <= |(next_irq_status & irq_mask);
      end
   end

   // Pixel placement with mirror and rotation
   assign addr_x = preview_orientation[1] ?
      13'(preview_out_width - 13'h0001 - pos_x) : pos_x;
   assign addr_y = preview_orientation[0] ?
      13'(preview_out_height - 13'h0001 - pos_y) : pos_y;
   assign lin_idx = 26'(addr_y * preview_out_width) + {13'h0000, addr_x};
   assign pix_addr = 32'(frame_base[o_frame_index] + {4'h0, lin_idx, 2'b00});

   // Burst choice: the tail burst closes the line
   assign words_left = 13'(preview_out_width - pos_x);
   assign pick_len = (words_left == {8'h00, preview_tail_burst_len}) ?
      preview_tail_burst_len : preview_main_burst_len;
   assign line_last = (pos_x == 13'(preview_out_width - 13'h0001));

   assign start_ok = i_frame_start && i_preview_capture_en &&
      (preview_out_width != 13'h0000) && (preview_out_height != 13'h0000);
   assign take_pix = (state == ST_RUN) && o_pix_ready && i_pix_valid;
   assign beat_done = o_mem_valid && i_mem_ready;
   assign frame_end = beat_done && last_pending;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state <= ST_IDLE;
         pos_x <= 13'h0000;
         pos_y <= 13'h0000;
         burst_left <= 5'h00;
         last_pending <= 1'b0;
         o_pix_ready <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_ok) begin
                  state <= ST_RUN;
                  pos_x <= 13'h0000;
                  pos_y <= 13'h0000;
                  burst_left <= 5'h00;
                  o_pix_ready <= 1'b1;
                  o_busy <= 1'b1;
               end
            end
            ST_RUN: begin
               if (take_pix) begin
                  o_pix_ready <= 1'b0;
                  if (burst_left == 5'h00) begin
                     burst_left <= 5'(pick_len - 5'h01);
                  end else begin
                     burst_left <= 5'(burst_left - 5'h01);
                  end
                  if (line_last) begin
                     pos_x <= 13'h0000;
                     pos_y <= 13'(pos_y + 13'h0001);
                     burst_left <= 5'h00;
                     last_pending <= (pos_y == 13'(preview_out_height - 13'h0001));
                  end else begin
                     pos_x <= 13'(pos_x + 13'h0001);
                  end
               end
               if (beat_done) begin
                  if (last_pending) begin
                     state <= ST_IDLE;
                     last_pending <= 1'b0;
                     o_busy <= 1'b0;
                  end else begin
                     o_pix_ready <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Memory write beat
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_mem_valid <= 1'b0;
         o_mem_addr <= `CPDMA_RST_WORD;
         o_mem_data <= `CPDMA_RST_WORD;
         o_mem_first <= 1'b0;
         o_mem_blen <= 5'h00;
      end else if (take_pix) begin
         o_mem_valid <= 1'b1;
         o_mem_addr <= pix_addr;
         o_mem_data <= i_pix_data;
         o_mem_first <= (burst_left == 5'h00);
         if (burst_left == 5'h00) begin
            o_mem_blen <= pick_len;
         end
      end else if (beat_done) begin
         o_mem_valid <= 1'b0;
      end
   end

   // Preview frame slot advances after each finished frame
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_frame_index <= 2'h0;
      end else if (frame_end) begin
         o_frame_index <= 2'(o_frame_index + 2'h1);
      end
   end

endmodule // cpdma_top

// ===== bench/cpdma_chk.sv
`timescale 1ns/1ns
`include "cpdma_map.svh"
module cpdma_chk
   import cpdma_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire cpdma_codec_s i_codec,
   input wire logic i_preview_capture_en,
   input wire logic i_frame_start,
   input wire logic i_pix_valid,
   input wire logic [31:0] i_pix_data,
   input wire logic o_pix_ready,
   input wire logic o_mem_valid,
   input wire logic [31:0] o_mem_addr,
   input wire logic [31:0] o_mem_data,
   input wire logic o_mem_first,
   input wire logic [4:0] o_mem_blen,
   input wire logic i_mem_ready,
   input wire logic [1:0] o_frame_index,
   input wire logic o_busy,
   input wire cpdma_scale_s o_scale,
   input wire logic o_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic [4:0] beat_cnt;
   logic st_rd;
   // Beats already taken in the current burst
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         beat_cnt <= 5'h0;
      end else if (o_mem_valid && i_mem_ready) begin
         beat_cnt <= o_mem_first ? 5'h1 : beat_cnt + 5'h1;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      st_rd <= i_wb_adr == `CPDMA_ADR_CODEC_STATUS && !i_wb_we;
   end
   ack_timing_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus request not acked one cycle later");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   status_bits_a: assert property (o_wb_ack && st_rd && $past(i_codec) == $past(i_codec, 2)
      && $past(i_codec, 2) == $past(i_codec, 3) |-> o_wb_dat[31:21] == $past(i_codec))
      else $error("status read does not show codec state");
   status_low_a: assert property (o_wb_ack && st_rd |-> o_wb_dat[20:0] == 21'h0)
      else $error("status reserved bits not zero");
   mem_hold_a: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid
      && $stable(o_mem_addr) && $stable(o_mem_data) && $stable(o_mem_blen))
      else $error("memory beat changed before accept");
   pix_beat_a: assert property (o_pix_ready && i_pix_valid |=> o_mem_valid && !o_pix_ready
      && o_mem_data == $past(i_pix_data))
      else $error("pixel not passed to memory beat");
   burst_len_a: assert property (o_mem_valid && !o_mem_first |-> beat_cnt < o_mem_blen)
      else $error("burst longer than its length");
   idle_quiet_a: assert property (!o_busy |-> !o_pix_ready && !o_mem_valid)
      else $error("stream active while idle");
   frame_step_a: assert property ($changed(o_frame_index) |->
      o_frame_index == $past(o_frame_index) + 2'h1 && $fell(o_busy))
      else $error("frame slot stepped wrongly");
   cover property (o_mem_valid && o_mem_first && o_mem_blen == 5'h2);
   cover property ($fell(o_busy));
   cover property (o_irq);
endmodule // cpdma_chk

bind cpdma_top cpdma_chk u_cpdma_chk (.*);

// ===== bench/cpdma_mem.sv
`timescale 1ns/1ns
module cpdma_mem (
   input wire logic i_clk_sys,
   input wire logic i_slow,
   input wire logic i_valid,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_data,
   input wire logic i_first,
   input wire logic [4:0] i_blen,
   output logic o_ready
);
   logic [31:0] mem [logic [31:0]];
   int bursts [$];
   // Stores each accepted beat and the length of each burst opened
   always @(posedge i_clk_sys) begin
      if (i_valid && o_ready) begin
         mem[i_addr] = i_data;
         if (i_first) bursts.push_back(int'(i_blen));
      end
      o_ready <= i_slow ? 1'($urandom_range(1)) : 1'b1;
   end
endmodule // cpdma_mem

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`include "cpdma_map.svh"
module tb_top;
   import cpdma_pkg::*;
   logic i_clk_sys, i_rst, cyc, stb, we, ack, pv, pr, fs, cap, mv, mf, mr, busy, irq, slow, msk;
   logic [31:0] adr, wdat, rdat, pd, ma, md, rd, bs [4], rv [8];
   logic [3:0] sel;
   logic [4:0] bl;
   logic [1:0] fidx;
   cpdma_codec_s codec;
   cpdma_scale_s scale;
   int errors, n_compared, cycles, fi;
   logic [31:0] exp_m [logic [31:0]];
   int exp_b [$];
   cpdma_top u_cpdma_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_codec(codec), .i_preview_capture_en(cap), .i_frame_start(fs),
      .i_pix_valid(pv), .i_pix_data(pd), .o_pix_ready(pr), .o_mem_valid(mv), .o_mem_addr(ma),
      .o_mem_data(md), .o_mem_first(mf), .o_mem_blen(bl), .i_mem_ready(mr),
      .o_frame_index(fidx), .o_busy(busy), .o_scale(scale), .o_irq(irq));
   cpdma_mem u_cpdma_mem (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_valid(mv), .i_addr(ma),
      .i_data(md), .i_first(mf), .i_blen(bl), .o_ready(mr));
   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         $display("BAD %0t timeout", $time);
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge i_clk_sys); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic logic [31:0] rm(input int i);
      return i < 4 ? 32'hffff_ffff : i == 4 ? 32'h1fff_dfff : i == 5 ? 32'h00ff_c004 :
         i == 6 ? 32'hf07f_007f : 32'h0fff_0fff;
   endfunction
   task automatic frame(input logic [1:0] o, input int w, input int h, input logic arm);
      int n, x, y;
      logic [31:0] px;
      wb(1'b1, `CPDMA_ADR_TARGET_FMT, {3'h0, 13'(w), o, 1'b0, 13'(h)});
      wb(1'b1, `CPDMA_ADR_DMA_CTRL, {8'h0, 5'h4, 5'h2, 11'h0, arm, 2'h0});
      for (y = 0; y < h; y++) begin
         for (n = w; n > 0; n -= (n == 2) ? 2 : 4) exp_b.push_back((n == 2) ? 2 : 4);
      end
      fs <= 1'b1;
      @(posedge i_clk_sys);
      fs <= 1'b0;
      px = $urandom;
      for (n = 0; n < w * h; ) begin
         pv <= 1'b1;
         pd <= px;
         @(posedge i_clk_sys);
         if (pr === 1'b1) begin
            x = o[1] ? w - 1 - n % w : n % w;
            y = o[0] ? h - 1 - n / w : n / w;
            exp_m[bs[fi] + 32'(4 * (y * w + x))] = px;
            px = $urandom;
            n++;
         end
      end
      pv <= 1'b0;
      do @(posedge i_clk_sys); while (busy !== 1'b0);
      fi = (fi + 1) % 4;
      chk({30'h0, fidx}, 32'(fi), "slot");
      foreach (exp_m[k]) chk(u_cpdma_mem.mem[k], exp_m[k], "pixel");
      chk(32'(u_cpdma_mem.bursts.size()), 32'(exp_b.size()), "bursts");
      foreach (exp_b[k]) chk(32'(u_cpdma_mem.bursts[k]), 32'(exp_b[k]), "blen");
      wb(1'b0, `CPDMA_ADR_IRQ_STATUS, 32'h0);
      chk(rd, {30'h0, arm, 1'b1}, "irq status");
      chk({31'h0, irq}, {31'h0, msk}, "irq line");
      wb(1'b1, `CPDMA_ADR_IRQ_STATUS, 32'h3);
      wb(1'b0, `CPDMA_ADR_DMA_CTRL, 32'h0);
      chk(rd, 32'h0020_8000, "arm clear");
      chk({31'h0, irq}, 32'h0, "irq clear");
      exp_m.delete();
      exp_b.delete();
      u_cpdma_mem.mem.delete();
      u_cpdma_mem.bursts.delete();
      $display("frame test %0d done", fi);
   endtask
   initial begin
      {cyc, stb, we, pv, fs, slow, msk} = '0;
      {adr, wdat, pd} = '0;
      sel = 4'hf;
      cap = 1'b1;
      codec = '0;
      i_rst = 1'b1;
      void'($urandom(32'h0000_bb4f));
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      wb(1'b0, `CPDMA_ADR_CODEC_STATUS, 32'h0);
      chk(rd, 32'h0, "status reset");
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 32'h4f00_006c + 32'(4 * i), 32'h0);
         chk(rd, 32'h0, "reset value");
         rv[i] = $urandom;
         wb(1'b1, 32'h4f00_006c + 32'(4 * i), rv[i]);
         wb(1'b0, 32'h4f00_006c + 32'(4 * i), 32'h0);
         chk(rd, rv[i] & rm(i), "read back");
      end
      chk({2'h0, scale[41:12]}, {2'h0, rv[6][31:28], rv[6][22:16], rv[6][6:0], rv[7][27:16]},
         "scale");
      chk({20'h0, scale[11:0]}, {20'h0, rv[7][11:0]}, "scale height");
      wb(1'b1, 32'h4f00_0068, 32'hffff_ffff);
      wb(1'b0, 32'h4f00_0068, 32'h0);
      chk(rd, 32'h0, "unmapped");
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         codec <= cpdma_codec_s'(11'($urandom));
         wb(1'b1, `CPDMA_ADR_CODEC_STATUS, 32'hffff_ffff);
         wb(1'b0, `CPDMA_ADR_CODEC_STATUS, 32'h0);
         chk(rd, {codec, 21'h0}, "status");
      end
      $display("status test done");
      for (int i = 0; i < 4; i++) begin
         bs[i] = 32'h2000_0000 + 32'(i) * 32'h0001_0000;
         wb(1'b1, 32'h4f00_006c + 32'(4 * i), bs[i]);
      end
      cap <= 1'b0;
      fs <= 1'b1;
      @(posedge i_clk_sys);
      fs <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      chk({31'h0, busy}, 32'h0, "start refused");
      cap <= 1'b1;
      for (int o = 0; o < 8; o++) begin
         slow <= o[2];
         if (o == 1) begin
            wb(1'b1, `CPDMA_ADR_IRQ_MASK, 32'h3);
            msk = 1'b1;
         end
         frame(2'(o % 4), 6 + 4 * (o % 2), 2 + o % 3, o == 2);
      end
      end_sim();
   end
endmodule // tb_top
